/* sac_host.sv */
// Local design decisions: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps
module sac_host
  import sac_pkg::*;
#(
  parameter int unsigned RangeFastCyc = RANGE_FAST_CYC,
  parameter int unsigned RangeSlowCyc = RANGE_SLOW_CYC,
  parameter int unsigned RefSettleCyc = REF_SETTLE_CYC,
  parameter int unsigned SleepWakeCyc = SLEEP_WAKE_CYC
)(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // Wishbone slave
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [3:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic [31:0]       wb_dat_o,
  output logic              wb_ack_o,
  // Link to the converter
  sac_link_if.host          link
);
  // ****************************************
  // Registers
  // ****************************************
  logic [4:0]            ctrl_r;
  logic                  startReq_r;
  logic                  start_n_r;
  logic [CNT_W-1:0]      wait_r;
  logic [2:0]            acq_r;
  logic [RES_BITS-1:0]   result_r;
  logic                  flag_r;
  logic                  valid_r;
  logic                  busyPrev_r;
  logic                  access;
  logic                  ready;
  logic [1:0]            newRange;

  assign access   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign newRange = {wb_dat_i[CTRL_RHI], wb_dat_i[CTRL_RLO]};
  assign ready    = (wait_r == '0) && (acq_r == '0) && start_n_r && busyPrev_r && link.busy_n;

  // Bus ack and read data
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= access;
      wb_dat_o <= 32'h0000_0000;
      if (access && !wb_we_i) begin
        case (wb_adr_i)
          REG_CTRL:   wb_dat_o <= {27'h0, ctrl_r};
          REG_STATUS: wb_dat_o <= {27'h0, flag_r && result_r[RES_BITS-1],
                                   flag_r && !result_r[RES_BITS-1],
                                   valid_r, ready, !busyPrev_r};
          REG_RESULT: wb_dat_o <= {17'h0, flag_r, result_r};
          default:    wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control settings; changes only while the link is idle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r <= CTRL_RESET[4:0];
    end else if (access && wb_we_i && wb_sel_i[0] && wb_adr_i == REG_CTRL && ready) begin
      ctrl_r <= {wb_dat_i[4:1], 1'b0};
    end
  end

  // Settling wait after range or power change
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_r <= CNT_W'(SleepWakeCyc);
    end else if (access && wb_we_i && wb_sel_i[0] && wb_adr_i == REG_CTRL && ready) begin
      if (!ctrl_r[CTRL_SLP_N] && wb_dat_i[CTRL_SLP_N]) begin
        wait_r <= CNT_W'(SleepWakeCyc);
      end else if (newRange != {ctrl_r[CTRL_RHI], ctrl_r[CTRL_RLO]}
                   && (newRange == RANGE_6DB || newRange == RANGE_9DB)) begin
        wait_r <= CNT_W'(RefSettleCyc);
      end else if (newRange == RANGE_3DB && ctrl_r[CTRL_RHI] && ctrl_r[CTRL_RLO]) begin
        wait_r <= CNT_W'(RangeSlowCyc);
      end else if (newRange != {ctrl_r[CTRL_RHI], ctrl_r[CTRL_RLO]}) begin
        wait_r <= CNT_W'(RangeFastCyc);
      end else if (!ctrl_r[CTRL_NAP_N] && wb_dat_i[CTRL_NAP_N]) begin
        wait_r <= CNT_W'(NAP_WAKE_CYC);
      end
    end else if (wait_r != '0) begin
      wait_r <= wait_r - 1'b1;
    end
  end

  // Start request latch; held until ready, dropped in power-down
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      startReq_r <= 1'b0;
    end else if (access && wb_we_i && wb_sel_i[0] && wb_adr_i == REG_CTRL
                 && wb_dat_i[CTRL_START]) begin
      startReq_r <= 1'b1;
    end else if (!ctrl_r[CTRL_SLP_N] || !ctrl_r[CTRL_NAP_N]) begin
      startReq_r <= 1'b0;
    end else if (ready && startReq_r) begin
      startReq_r <= 1'b0;
    end
  end

  // One-cycle low start pulse, then acquisition guard
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      start_n_r <= 1'b1;
      acq_r     <= 3'h0;
    end else begin
      start_n_r <= !(ready && startReq_r && ctrl_r[CTRL_SLP_N] && ctrl_r[CTRL_NAP_N]);
      if (busyPrev_r == 1'b0 && link.busy_n) begin
        acq_r <= 3'(ACQ_CYC);
      end else if (acq_r != 3'h0) begin
        acq_r <= acq_r - 3'h1;
      end
    end
  end

  // Capture on busy falling edge: previous conversion result
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busyPrev_r <= 1'b1;
      result_r   <= CODE_ZERO;
      flag_r     <= 1'b0;
      valid_r    <= 1'b0;
    end else begin
      busyPrev_r <= link.busy_n;
      if (busyPrev_r && !link.busy_n) begin
        result_r <= link.resultWord;
        flag_r   <= link.outOfRangeFlag;
        valid_r  <= 1'b1;
      end
    end
  end

  assign link.conversionStart_n = start_n_r;
  assign link.rangeSelectLo     = ctrl_r[CTRL_RLO];
  assign link.rangeSelectHi     = ctrl_r[CTRL_RHI];
  assign link.lightPowerdown_n  = ctrl_r[CTRL_NAP_N];
  assign link.deepPowerdown_n   = ctrl_r[CTRL_SLP_N];
endmodule

/* sac_pkg.sv */
package sac_pkg;
  // ****************************************
  // Widths and timing
  // ****************************************
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned RES_BITS        = 14;
  localparam int unsigned CONV_NS         = 260;
  localparam int unsigned ACQ_NS          = 100;
  localparam int unsigned NAP_WAKE_NS     = 250;
  localparam int unsigned RANGE_FAST_US   = 600;
  localparam int unsigned RANGE_SLOW_MS   = 11;
  localparam int unsigned REF_SETTLE_MS   = 700;
  localparam int unsigned SLEEP_WAKE_MS   = 210;
  // Cycle counts: least times rounded up, conversion time rounded down
  localparam int unsigned CONV_CYC     = (CONV_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned ACQ_CYC      = (ACQ_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned NAP_WAKE_CYC = (NAP_WAKE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned RANGE_FAST_CYC = RANGE_FAST_US * (CLK_HZ / 1_000_000);
  localparam int unsigned RANGE_SLOW_CYC = RANGE_SLOW_MS * (CLK_HZ / 1000);
  localparam int unsigned REF_SETTLE_CYC = REF_SETTLE_MS * (CLK_HZ / 1000);
  localparam int unsigned SLEEP_WAKE_CYC = SLEEP_WAKE_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W = 26;
  // ****************************************
  // Range encoding {hi, lo}
  // ****************************************
  localparam logic [1:0] RANGE_0DB = 2'h3;
  localparam logic [1:0] RANGE_3DB = 2'h2;
  localparam logic [1:0] RANGE_6DB = 2'h1;
  localparam logic [1:0] RANGE_9DB = 2'h0;
  // Full-scale half spans in microvolts per range
  localparam int unsigned SPAN_0DB_UV = 1_800_000;
  localparam int unsigned SPAN_3DB_UV = 1_280_000;
  localparam int unsigned SPAN_6DB_UV = 900_000;
  localparam int unsigned SPAN_9DB_UV = 640_000;
  localparam int unsigned OVR_LSB = 64;
  localparam logic [RES_BITS-1:0] CODE_MOST_NEG = 14'h2000;
  localparam logic [RES_BITS-1:0] CODE_MOST_POS = 14'h1FFF;
  localparam logic [RES_BITS-1:0] CODE_ZERO     = 14'h0000;
  // ****************************************
  // Host command port registers (word byte addresses)
  // ****************************************
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_RESULT = 4'h8;
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_RLO   = 1;
  localparam int unsigned CTRL_RHI   = 2;
  localparam int unsigned CTRL_NAP_N = 3;
  localparam int unsigned CTRL_SLP_N = 4;
  localparam int unsigned STAT_BUSY  = 0;
  localparam int unsigned STAT_READY = 1;
  localparam int unsigned STAT_VALID = 2;
  localparam int unsigned STAT_OVR   = 3;
  localparam int unsigned STAT_UNDR  = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_001E;
  // ****************************************
  // States
  // ****************************************
  typedef enum logic [1:0] {
    SAC_IDLE = 2'b00,
    SAC_CONV = 2'b01,
    SAC_DONE = 2'b11
  } sac_dev_state_t;
endpackage

/* sac_link_if.sv */
`timescale 1ns/100ps
interface sac_link_if;
  logic                 conversionStart_n;
  logic                 rangeSelectLo;
  logic                 rangeSelectHi;
  logic                 lightPowerdown_n;
  logic                 deepPowerdown_n;
  logic                 busy_n;
  logic [13:0]          resultWord;
  logic                 outOfRangeFlag;
  // Documented converter end
  modport device (
    input  conversionStart_n, rangeSelectLo, rangeSelectHi, lightPowerdown_n, deepPowerdown_n,
    output busy_n, resultWord, outOfRangeFlag
  );
  // Host controller end
  modport host (
    output conversionStart_n, rangeSelectLo, rangeSelectHi, lightPowerdown_n, deepPowerdown_n,
    input  busy_n, resultWord, outOfRangeFlag
  );
endinterface

/* sac_device.sv */
`timescale 1ns/100ps
module sac_device
  import sac_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // Link to the host
  sac_link_if.device               link,
  // Analog stand-in: input difference in microvolts, signed
  input  wire logic signed [31:0]  analogInUv,
  // Status
  output logic                     referenceOn,
  output logic                     poweredUp
);
  // ****************************************
  // Conversion sequencing
  // ****************************************
  sac_dev_state_t                state_r;
  logic                          startPrev_r;
  logic [3:0]                    bitIdx_r;
  logic [RES_BITS-1:0]           sar_r;
  logic signed [31:0]            heldUv_r;
  logic [RES_BITS-1:0]           resultWord_r;
  logic                          outOfRange_r;
  logic                          busy_n_r;
  logic                          holdOvr_r;
  logic                          holdUndr_r;
  logic signed [31:0]            spanUv;
  logic signed [63:0]            spanWide;
  logic signed [63:0]            trialWide;
  logic signed [63:0]            trialThr;
  logic signed [63:0]            heldScaled;
  logic signed [63:0]            inScaled;
  logic signed [63:0]            ovrThr;
  logic                          startFall;
  logic                          active;
  logic [RES_BITS-1:0]           trialCode;

  // ****************************************
  // Span selection and power state
  // ****************************************
  // Selected half span from the select inputs
  always_comb begin
    case ({link.rangeSelectHi, link.rangeSelectLo})
      RANGE_0DB: spanUv = SPAN_0DB_UV;
      RANGE_3DB: spanUv = SPAN_3DB_UV;
      RANGE_6DB: spanUv = SPAN_6DB_UV;
      default:   spanUv = SPAN_9DB_UV;
    endcase
  end

  // Power state: deep shuts all, light keeps reference
  assign active = link.deepPowerdown_n && link.lightPowerdown_n;
  // Start edge: high last cycle, low now
  assign startFall = startPrev_r && !link.conversionStart_n;

  // ****************************************
  // Decision thresholds
  // ****************************************
  // All levels but the under-range limit scaled by 2^14 so a step never rounds;
  // an integer step size would drift by many codes near full scale
  // Half span widened for the scaled products
  assign spanWide   = 64'(spanUv);
  assign heldScaled = 64'(heldUv_r) <<< RES_BITS;
  assign inScaled   = 64'(analogInUv) <<< RES_BITS;

  // Trial code with current bit set, as a signed count of steps
  assign trialCode = sar_r | (CODE_MOST_NEG >> bitIdx_r);
  // Sign bit copied into the upper bits
  assign trialWide = $signed({{(64 - RES_BITS){trialCode[RES_BITS-1]}}, trialCode});

  // Code c needs at least c - 1/2 steps: transitions sit midway
  assign trialThr = (64'sd2 * trialWide - 64'sd1) * spanWide;

  // Over-range starts 64 steps past the positive end of the span
  assign ovrThr = spanWide * ((64'sd1 <<< RES_BITS) + $signed(64'(2 * OVR_LSB)));

  // ****************************************
  // Sequencing
  // ****************************************
  // Start edge history
  // Reset value is the idle level, so no false edge follows reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      startPrev_r <= 1'b1;
    end else begin
      startPrev_r <= link.conversionStart_n;
    end
  end

  // SAR state machine, MSB to LSB
  // Starts are looked at in the idle state only
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r    <= SAC_IDLE;
      bitIdx_r   <= 4'h0;
      sar_r      <= CODE_ZERO;
      heldUv_r   <= 32'sh0;
      busy_n_r   <= 1'b1;
      holdOvr_r  <= 1'b0;
      holdUndr_r <= 1'b0;
    end else begin
      case (state_r)
        SAC_IDLE: begin
          if (startFall && active) begin
            state_r    <= SAC_CONV;
            busy_n_r   <= 1'b0;
            heldUv_r   <= analogInUv;
            bitIdx_r   <= 4'h0;
            sar_r      <= CODE_MOST_NEG;
            // Out-of-span inputs are judged on the held sample
            holdOvr_r  <= inScaled > ovrThr;
            holdUndr_r <= analogInUv < -spanUv;
          end
        end
        SAC_CONV: begin
          // Start requests are not looked at here
          if (bitIdx_r == 4'h0) begin
            // Sign bit: set means negative
            sar_r <= (heldScaled < -spanWide) ? CODE_MOST_NEG : CODE_ZERO;
          end else if (heldScaled >= trialThr) begin
            sar_r <= trialCode;
          end
          if (bitIdx_r == 4'(RES_BITS - 1)) begin
            state_r  <= SAC_DONE;
            busy_n_r <= 1'b1;
          end else begin
            bitIdx_r <= bitIdx_r + 4'h1;
          end
        end
        SAC_DONE: begin
          // Latches load here; a start now is ignored
          state_r <= SAC_IDLE;
        end
        default: begin
          state_r <= SAC_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Output latches
  // ****************************************
  // Output latches load one cycle after busy rises
  // Inputs past either end clamp to the end codes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      resultWord_r <= CODE_ZERO;
      outOfRange_r <= 1'b0;
    end else if (state_r == SAC_DONE) begin
      if (holdUndr_r) begin
        resultWord_r <= CODE_MOST_NEG;
      end else if (holdOvr_r) begin
        resultWord_r <= CODE_MOST_POS;
      end else begin
        resultWord_r <= sar_r;
      end
      outOfRange_r <= holdOvr_r || holdUndr_r || (sar_r == CODE_MOST_NEG);
    end
  end

  // ****************************************
  // Power status
  // ****************************************
  // Power status flags
  // Reference stays up unless deep power-down
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      referenceOn <= 1'b0;
      poweredUp   <= 1'b0;
    end else begin
      referenceOn <= link.deepPowerdown_n;
      poweredUp   <= active;
    end
  end

  // ****************************************
  // Link outputs
  // ****************************************
  // Link pins straight from registers
  assign link.busy_n         = busy_n_r;
  assign link.resultWord     = resultWord_r;
  assign link.outOfRangeFlag = outOfRange_r;
endmodule

/* sac_link_chk.sv */
`timescale 1ns/100ps
module sac_link_chk
  import sac_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Host-driven link lines
  input wire logic        conversionStart_n,
  input wire logic        rangeSelectLo,
  input wire logic        rangeSelectHi,
  input wire logic        lightPowerdown_n,
  input wire logic        deepPowerdown_n,
  // Converter-driven link lines
  input wire logic        busy_n,
  input wire logic [13:0] resultWord,
  input wire logic        outOfRangeFlag
);
  // ****************************************
  // Link assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Either power-down input active
  logic pd;
  assign pd = !lightPowerdown_n || !deepPowerdown_n;

  // Start edge, busy timing and word timing
  AST_START_BUSY: assert property (
    $fell(conversionStart_n) && busy_n && !pd |-> ##[1:2] !busy_n)
    else $error("start edge gave no busy");
  AST_BUSY_LEN: assert property (
    $fell(busy_n) |-> (!busy_n)[*8] ##1 (!busy_n)[*6] ##1 busy_n)
    else $error("busy low length wrong");
  AST_BUSY_CAUSE: assert property (
    $fell(busy_n) |-> !$past(conversionStart_n) || !$past(conversionStart_n, 2))
    else $error("busy fell without a start");
  AST_WORD_TIME: assert property (
    $changed(resultWord) && deepPowerdown_n && $past(deepPowerdown_n)
      |-> $past(busy_n) && !$past(busy_n, 2))
    else $error("word changed outside end of conversion");
  AST_FLAG_TIME: assert property (
    $changed(outOfRangeFlag) && deepPowerdown_n && $past(deepPowerdown_n)
      |-> $past(busy_n) && !$past(busy_n, 2))
    else $error("flag changed outside end of conversion");
  AST_NEG_FLAG: assert property (
    resultWord == CODE_MOST_NEG |-> outOfRangeFlag)
    else $error("most negative code without flag");
  AST_POS_FLAG: assert property (
    outOfRangeFlag && !resultWord[13] |-> resultWord == CODE_MOST_POS)
    else $error("flag with in-range positive code");
  AST_PD_IDLE: assert property (
    pd && $past(pd) && busy_n |=> busy_n)
    else $error("conversion during power-down");
  AST_RANGE_HOLD: assert property (
    !busy_n |-> $stable({rangeSelectHi, rangeSelectLo}))
    else $error("range select moved while busy");

  // Main scenarios reached
  cover property ($fell(busy_n));
  cover property (outOfRangeFlag && resultWord[13]);
  cover property (outOfRangeFlag && !resultWord[13]);
  cover property (pd && busy_n);
endmodule

/* tb_top.sv */
`timescale 1ns/100ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("unexpected at %0t: got %h exp %h", $time, (got), (exp)); end end
module tb_top;
  import sac_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic               clk;
  logic               sys_rst;
  logic               wbCyc;
  logic               wbStb;
  logic               wbWe;
  logic [3:0]         wbAdr;
  logic [3:0]         wbSel;
  logic [31:0]        wbDatW;
  logic [31:0]        wbDatR;
  logic               wbAck;
  logic signed [31:0] analogInUv;
  logic               referenceOn;
  logic               poweredUp;
  logic [31:0]        rd;
  logic [13:0]        prevWord;
  logic               prevFlag;
  logic [1:0]         rng;
  int                 mismatches;
  int                 checks;
  int                 ks [6] = '{4096, -4096, -8192, 8300, 8200, 0};

  // ****************************************
  // Design and checker
  // ****************************************
  sac_link_if u_sac_link_if ();
  sac_device u_sac_device (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .link        (u_sac_link_if.device),
    .analogInUv  (analogInUv),
    .referenceOn (referenceOn),
    .poweredUp   (poweredUp)
  );
  sac_host #(
    .RangeFastCyc (20),
    .RangeSlowCyc (20),
    .RefSettleCyc (20),
    .SleepWakeCyc (20)
  ) u_sac_host (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .wb_cyc_i (wbCyc),
    .wb_stb_i (wbStb),
    .wb_we_i  (wbWe),
    .wb_adr_i (wbAdr),
    .wb_sel_i (wbSel),
    .wb_dat_i (wbDatW),
    .wb_dat_o (wbDatR),
    .wb_ack_o (wbAck),
    .link     (u_sac_link_if.host)
  );
  sac_link_chk u_sac_link_chk (
    .clk               (clk),
    .sys_rst           (sys_rst),
    .conversionStart_n (u_sac_link_if.conversionStart_n),
    .rangeSelectLo     (u_sac_link_if.rangeSelectLo),
    .rangeSelectHi     (u_sac_link_if.rangeSelectHi),
    .lightPowerdown_n  (u_sac_link_if.lightPowerdown_n),
    .deepPowerdown_n   (u_sac_link_if.deepPowerdown_n),
    .busy_n            (u_sac_link_if.busy_n),
    .resultWord        (u_sac_link_if.resultWord),
    .outOfRangeFlag    (u_sac_link_if.outOfRangeFlag)
  );

  // ****************************************
  // Helpers
  // ****************************************
  // Half span of a range in microvolts
  function automatic longint spanOf(input logic [1:0] r);
    case (r)
      RANGE_0DB: return SPAN_0DB_UV;
      RANGE_3DB: return SPAN_3DB_UV;
      RANGE_6DB: return SPAN_6DB_UV;
      default:   return SPAN_9DB_UV;
    endcase
  endfunction

  // Classic single Wishbone cycle, held until ack
  task automatic wbXfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDatW <= d;
    wbSel <= 4'hF;
    do begin
      @(posedge clk);
    end while (wbAck !== 1'b1);
    rd = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask

  // Poll status until the controller reports ready
  task automatic waitReady();
    int n;
    n = 0;
    do begin
      wbXfer(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (rd[STAT_READY] !== 1'b1 && n < 200);
    `CHK(rd[STAT_READY], 1'b1)
  endtask

  // One conversion of k steps in range r, then link and register checks
  task automatic convert(input logic [1:0] r, input int k);
    int n;
    logic [13:0] expW;
    logic        expF;
    analogInUv <= 32'(longint'(k) * spanOf(r) / 8192);
    expW = (k > 8191) ? 14'h1FFF : 14'(k);
    expF = (k <= -8192) || (k > 8192 + int'(OVR_LSB));
    wbXfer(1'b1, REG_CTRL, {27'h0, 2'b11, r, 1'b1});
    n = 0;
    while (u_sac_link_if.busy_n !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    `CHK(u_sac_link_if.busy_n, 1'b0)
    while (u_sac_link_if.busy_n !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    `CHK(u_sac_link_if.busy_n, 1'b1)
    repeat (2) @(posedge clk);
    `CHK(u_sac_link_if.resultWord, expW)
    `CHK(u_sac_link_if.outOfRangeFlag, expF)
    wbXfer(1'b0, REG_RESULT, 32'h0);
    `CHK(rd[14:0], {prevFlag, prevWord})
    wbXfer(1'b0, REG_STATUS, 32'h0);
    `CHK(rd[4:3], {prevFlag & prevWord[13], prevFlag & ~prevWord[13]})
    prevWord = expW;
    prevFlag = expF;
  endtask

  // Counts and verdict
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ****************************************
  // Clock, watchdog and tests
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Hang guard, well past the expected run length
  initial begin
    #400_000;
    mismatches++;
    summarize();
  end

  // Main sequence
  initial begin
    {sys_rst, wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatW} = {1'b1, 43'h0};
    {analogInUv, mismatches, checks, prevWord, prevFlag} = '0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    waitReady();
    wbXfer(1'b1, REG_CTRL, 32'h0000_0017);
    repeat (8) @(posedge clk);
    `CHK(u_sac_link_if.busy_n, 1'b1)
    `CHK(referenceOn, 1'b1)
    `CHK(poweredUp, 1'b0)
    wbXfer(1'b1, REG_CTRL, 32'h0000_000F);
    repeat (8) @(posedge clk);
    `CHK(u_sac_link_if.busy_n, 1'b1)
    `CHK(referenceOn, 1'b0)
    `CHK(poweredUp, 1'b0)
    wbXfer(1'b1, REG_CTRL, CTRL_RESET);
    waitReady();
    `CHK(poweredUp, 1'b1)
    wbXfer(1'b0, REG_CTRL, 32'h0);
    `CHK(rd[4:0], CTRL_RESET[4:0])
    $display("test power-down done");
    for (int r = 0; r < 4; r++) begin
      rng = 2'(3 - r);
      wbXfer(1'b1, REG_CTRL, {27'h0, 2'b11, rng, 1'b0});
      waitReady();
      foreach (ks[i]) convert(rng, ks[i]);
      $display("test range %0d done", r);
    end
    summarize();
  end
endmodule
